// ---- include/retclr_regs.svh ----
// Constants for the return and clear instruction execution block.
`ifndef RETCLR_REGS_SVH
`define RETCLR_REGS_SVH

// ==========================================
// Instruction encodings
`define OPC_RETURN_FROM_INTERRUPT 14'h0009
`define OPC_RETURN_SUB            14'h0008
`define OPC_WATCHDOG_CLEAR        14'h0064
`define OPC_RET_LIT_MASK          14'h3C00
`define OPC_RET_LIT_VALUE         14'h3400
`define OPC_CLEAR_MASK            14'h3F80
`define OPC_FILE_CLEAR_VALUE      14'h0180
`define OPC_ACC_CLEAR_VALUE       14'h0100

// ==========================================
// Field positions, interrupt vector address and reset values
`define GLOBAL_ENABLE_BIT         7
`define INTERRUPT_VECTOR          13'h0004
`define GLOBAL_ENABLE_RESET       1'h0

// ==========================================
// Quarter phases of one instruction cycle
`define QUARTER_Q1                2'h0
`define QUARTER_Q2                2'h1
`define QUARTER_Q3                2'h2
`define QUARTER_Q4                2'h3

`endif

// ---- include/retclr_pkg.sv ----
// Types shared by the return and clear instruction execution block.
package retclr_pkg;

	// ==========================================
	// Decoded operations
	typedef enum logic [2:0] {
		op_none,
		op_return_from_interrupt,
		op_return_sub,
		op_return_with_literal,
		op_watchdog_clear_instr,
		op_file_register_clear,
		op_accumulator_clear,
		op_interrupt_accept
	} op_type;

	// ==========================================
	// Execution side effects, one quarter wide each except flush, which is held for four quarters
	typedef struct packed {
		logic        pc_load;
		logic [12:0] pc_value;
		logic        stack_pop;
		logic        stack_push;
		logic [12:0] push_value;
		logic        w_write;
		logic [7:0]  w_value;
		logic        file_read;
		logic        file_write;
		logic [6:0]  file_addr;
		logic [7:0]  file_value;
		logic        zero_set;
		logic        watchdog_counter_clear;
		logic        prescaler_clear;
		logic        timeout_status_bit_set;
		logic        powerdown_status_bit_set;
		logic        flush;
	} exec_out_type;

endpackage

// ---- core/return_and_clear_instr_exec.sv ----
// Execution logic for return, register clear and watchdog clear instructions.
//
// Functional notes
// RQ1: Return from interrupt pops the stack top entry into the program counter.
// RQ2: Return from interrupt sets the global interrupt enable, bit 7 of the interrupt control register.
// RQ3: Return from interrupt takes two cycles, setting the enable in Q3, popping in Q4, second cycle idle.
// RQ4: Return from subroutine pops the stack top entry into the program counter and touches no flag.
// RQ5: Return from subroutine pops in Q4 of its first cycle and idles in the second cycle.
// RQ6: Return with literal loads the 8-bit literal into W and pops the stack into the program counter.
// RQ7: Return with literal reads the literal in Q2, writes W and pops in Q4, then idles one cycle.
// RQ8: Watchdog clear resets the watchdog counter and prescaler and sets both status bits in one cycle.
// RQ9: File register clear reads in Q2, writes zero in Q4 and sets the zero flag.
// RQ10: An accepted interrupt clears the global enable, pushes the return address and jumps to the vector.
// RQ11: Every reset clears the global interrupt enable.
`include "retclr_regs.svh"

module return_and_clear_instr_exec
	import retclr_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic [13:0]  instr,
	input  wire logic [12:0]  stack_top_entry,
	input  wire logic [12:0]  return_address,
	input  wire logic         irq_pending,
	input  wire logic         interrupt_control_write,
	input  wire logic [7:0]   interrupt_control_wdata,
	output logic [1:0]        quarter,
	output logic              global_interrupt_enable,
	output exec_out_type      exec_out
);

	// ==========================================
	// Cycle sequencing
	typedef enum logic {
		st_execute,
		st_flush
	} cycle_state_type;

	cycle_state_type state;
	cycle_state_type next_state;
	logic [1:0]      next_quarter;
	op_type          op;
	op_type          next_op;
	logic [7:0]      literal;
	logic [7:0]      next_literal;
	logic [6:0]      faddr;
	logic [6:0]      next_faddr;
	logic            next_global_interrupt_enable;
	exec_out_type    next_exec_out;
	op_type          decoded;

	// Decoding is pure; the decode is used in Q1 and the literal byte of the instruction word is read again in Q2.
	always_comb begin
		decoded = op_none;
		if (instr == `OPC_RETURN_FROM_INTERRUPT) begin
			decoded = op_return_from_interrupt;
		end else if (instr == `OPC_RETURN_SUB) begin
			decoded = op_return_sub;
		end else if (instr == `OPC_WATCHDOG_CLEAR) begin
			decoded = op_watchdog_clear_instr;
		end else if ((instr & `OPC_RET_LIT_MASK) == `OPC_RET_LIT_VALUE) begin
			decoded = op_return_with_literal;
		end else if ((instr & `OPC_CLEAR_MASK) == `OPC_FILE_CLEAR_VALUE) begin
			decoded = op_file_register_clear;
		end else if ((instr & `OPC_CLEAR_MASK) == `OPC_ACC_CLEAR_VALUE) begin
			decoded = op_accumulator_clear;
		end
	end

	always_comb begin
		next_quarter  = quarter + 2'h1;
		next_state    = state;
		next_op       = op;
		next_literal  = literal;
		next_faddr    = faddr;
		next_global_interrupt_enable = global_interrupt_enable;
		next_exec_out = '0;
		next_exec_out.flush = (state == st_flush);

		case (quarter)
			`QUARTER_Q1: begin
				if (state == st_flush) begin
					next_op = op_none;
				end else if (irq_pending && global_interrupt_enable) begin
					// Acceptance takes the place of the instruction being decoded.
					next_op = op_interrupt_accept;
				end else begin
					next_op = decoded;
					next_faddr = instr[6:0];
				end
			end
			`QUARTER_Q2: begin
				// RQ7: literal read in Q2
				if (op == op_return_with_literal) begin
					next_literal = instr[7:0];
				end
				// RQ9: register read in Q2
				if (op == op_file_register_clear) begin
					next_exec_out.file_read = 1'h1;
					next_exec_out.file_addr = faddr;
				end
			end
			`QUARTER_Q3: begin
				// RQ2: enable set in Q3
				// RQ3: first-cycle Q3 action
				if (op == op_return_from_interrupt) begin
					next_global_interrupt_enable = 1'h1;
				end
			end
			`QUARTER_Q4: begin
				// A software write lands in Q4; it never overlaps the Q3 set.
				if (interrupt_control_write) begin
					next_global_interrupt_enable = interrupt_control_wdata[`GLOBAL_ENABLE_BIT];
				end
				next_state = st_execute;
				case (op)
					op_return_from_interrupt, op_return_sub, op_return_with_literal: begin
						// RQ1: pop into program counter
						// RQ4: pop with no flag change
						// RQ6: pop with literal return
						next_exec_out.stack_pop = 1'h1;
						next_exec_out.pc_load   = 1'h1;
						next_exec_out.pc_value  = stack_top_entry;
						// RQ3: second cycle flushed
						// RQ5: second cycle idle
						next_state = st_flush;
						if (op == op_return_with_literal) begin
							// RQ7: write W in Q4
							next_exec_out.w_write = 1'h1;
							next_exec_out.w_value = literal;
						end
					end
					op_watchdog_clear_instr: begin
						// RQ8: clear watchdog, set status
						next_exec_out.watchdog_counter_clear   = 1'h1;
						next_exec_out.prescaler_clear          = 1'h1;
						next_exec_out.timeout_status_bit_set   = 1'h1;
						next_exec_out.powerdown_status_bit_set = 1'h1;
					end
					op_file_register_clear: begin
						// RQ9: write zero, set Z
						next_exec_out.file_write = 1'h1;
						next_exec_out.file_addr  = faddr;
						next_exec_out.file_value = 8'h00;
						next_exec_out.zero_set   = 1'h1;
					end
					op_accumulator_clear: begin
						next_exec_out.w_write  = 1'h1;
						next_exec_out.w_value  = 8'h00;
						next_exec_out.zero_set = 1'h1;
					end
					op_interrupt_accept: begin
						// RQ10: clear enable, push, vector
						next_global_interrupt_enable = 1'h0;
						next_exec_out.stack_push = 1'h1;
						next_exec_out.push_value = return_address;
						next_exec_out.pc_load    = 1'h1;
						next_exec_out.pc_value   = `INTERRUPT_VECTOR;
						next_state = st_flush;
					end
					default: begin
						next_state = st_execute;
					end
				endcase
			end
			default: begin
				next_quarter = `QUARTER_Q1;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			quarter  <= `QUARTER_Q1;
			state    <= st_execute;
			op       <= op_none;
			literal  <= 8'h00;
			faddr    <= 7'h00;
			// RQ11: enable cleared by reset
			global_interrupt_enable <= `GLOBAL_ENABLE_RESET;
			exec_out <= '0;
		end else begin
			quarter  <= next_quarter;
			state    <= next_state;
			op       <= next_op;
			literal  <= next_literal;
			faddr    <= next_faddr;
			global_interrupt_enable <= next_global_interrupt_enable;
			exec_out <= next_exec_out;
		end
	end

endmodule

// ---- bench/retclr_checker_assertions.sv ----
// Assertion checker for the return and clear instruction execution block.
module retclr_checker
	import retclr_pkg::*;
(
	input wire logic		clk,
	input wire logic		rstn,
	input wire logic [13:0]		instr,
	input wire logic [12:0]		stack_top_entry,
	input wire logic [12:0]		return_address,
	input wire logic		irq_pending,
	input wire logic		interrupt_control_write,
	input wire logic [7:0]		interrupt_control_wdata,
	input wire logic [1:0]		quarter,
	input wire logic		global_interrupt_enable,
	input wire exec_out_type	exec_out
);
	// ==========================================
	// Properties
	wire logic [7:0] lit = instr[7:0];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	a_quarter_step: assert property ($past(rstn) |-> quarter == 2'($past(quarter) + 2'h1)) else $error("quarter skipped");
	a_pop_loads_pc: assert property (exec_out.stack_pop |-> exec_out.pc_load
		&& exec_out.pc_value == $past(stack_top_entry)) else $error("pop without stack top load");
	a_pop_quarter: assert property (exec_out.stack_pop |-> quarter == 2'h0) else $error("pop out of Q4");
	a_enable_then_pop: assert property ($rose(global_interrupt_enable) && quarter == 2'h3 |=> exec_out.stack_pop)
		else $error("enable set without pop");
	a_pop_flush: assert property (exec_out.stack_pop |-> ##[0:1] exec_out.flush [*4]) else $error("no flush cycle");
	a_irq_vector: assert property (exec_out.stack_push |-> exec_out.pc_load && exec_out.pc_value == 13'h0004
		&& exec_out.push_value == $past(return_address) && !global_interrupt_enable) else $error("bad vectoring");
	// accept only when enabled at decode
	a_accept_enabled: assert property (exec_out.stack_push |-> $past(global_interrupt_enable, 4))
		else $error("interrupt taken while disabled");
	a_literal_w: assert property (exec_out.stack_pop && exec_out.w_write |-> exec_out.w_value == $past(lit, 3))
		else $error("wrong literal");
	a_watchdog_group: assert property (exec_out.watchdog_counter_clear |-> exec_out.prescaler_clear
		&& quarter == 2'h0 && exec_out.timeout_status_bit_set && exec_out.powerdown_status_bit_set)
		else $error("partial clear");
	a_file_clear: assert property (exec_out.file_write |-> exec_out.file_value == 8'h00 && exec_out.zero_set
		&& $past(exec_out.file_read, 2)) else $error("bad register clear");
	a_enable_reset: assert property (disable iff (1'b0) !rstn |=> !global_interrupt_enable) else $error("enable kept");
	c_enable_rise: cover property ($rose(global_interrupt_enable));
	c_irq_push: cover property (exec_out.stack_push);
	c_watchdog_clear: cover property (exec_out.watchdog_counter_clear);
endmodule
bind return_and_clear_instr_exec retclr_checker chk (.clk(clk), .rstn(rstn), .instr(instr),
	.stack_top_entry(stack_top_entry), .return_address(return_address), .irq_pending(irq_pending),
	.interrupt_control_write(interrupt_control_write), .interrupt_control_wdata(interrupt_control_wdata),
	.quarter(quarter), .global_interrupt_enable(global_interrupt_enable), .exec_out(exec_out));

// ---- bench/return_and_clear_instr_exec_tb.sv ----
// Self-checking bench for the return and clear instruction execution block.
`include "retclr_regs.svh"
module return_and_clear_instr_exec_tb
	import retclr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic		clk = 1'h0, rstn = 1'h0, irq_pending = 1'h0, interrupt_control_write = 1'h0;
	logic [13:0]	instr = 14'h0000;
	logic [12:0]	stack_top_entry = 13'h0000, return_address = 13'h0000;
	logic [7:0]	interrupt_control_wdata = 8'h00, k;
	logic [1:0]	quarter;
	logic		global_interrupt_enable;
	exec_out_type	exec_out, e, notes[$];
	int		failures = 0, tests_run = 0;
	integer		seed = 32'h8BC3B826;
	always #50 clk = ~clk;
	return_and_clear_instr_exec uut (.clk(clk), .rstn(rstn), .instr(instr), .stack_top_entry(stack_top_entry),
		.return_address(return_address), .irq_pending(irq_pending),
		.interrupt_control_write(interrupt_control_write), .interrupt_control_wdata(interrupt_control_wdata),
		.quarter(quarter), .global_interrupt_enable(global_interrupt_enable),
		.exec_out(exec_out));
	// ==========================================
	// Checking helpers
	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h got %h", what, exp, got);
		end
	endtask
	task automatic end_of_test;
		if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Only fields that the operation qualifies are compared, since the rest may hold stale data.
	function automatic exec_out_type norm(exec_out_type x);
		if (!x.pc_load) x.pc_value = 13'h0000;
		if (!x.stack_push) x.push_value = 13'h0000;
		if (!x.w_write) x.w_value = 8'h00;
		if (!x.file_write) x.file_value = 8'h00;
		if (!x.file_write) x.file_addr = 7'h00;
		x.file_read = 1'h0;
		x.flush = 1'h0;
		return x;
	endfunction
	always @(negedge clk) begin
		if (rstn && norm(exec_out) !== '0) begin
			if (notes.size() == 0) check("unexpected effect", '0, norm(exec_out));
			else check("exec_out", notes.pop_front(), norm(exec_out));
		end
	end
	// A flushed cycle carries a watchdog clear and a raised interrupt, both of which must be ignored.
	task automatic op(input logic [13:0] code, input logic irq, input logic two, input exec_out_type x);
		instr = code;
		irq_pending = irq;
		if (x !== '0) notes.push_back(x);
		repeat (4) @(posedge clk);
		#10;
		check("quarter at cycle end", 0, quarter);
		if (two) begin
			instr = `OPC_WATCHDOG_CLEAR;
			irq_pending = 1'h1;
			repeat (4) @(posedge clk);
			#10;
		end
	endtask
	initial begin
		#200000 failures++;
		end_of_test();
	end
	// ==========================================
	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		#10 rstn = 1'h1;
		for (int i = 0; i < 4; i++) begin
			k = 8'($random(seed));
			stack_top_entry = 13'($random(seed));
			return_address = 13'($random(seed));
			e = '{pc_load: 1'h1, pc_value: stack_top_entry, stack_pop: 1'h1, w_write: 1'h1, w_value: k, default: 0};
			op(`OPC_RET_LIT_VALUE | {4'h0, 2'(i), k}, 1'h0, 1'h1, e);
			e = '{pc_load: 1'h1, pc_value: stack_top_entry, stack_pop: 1'h1, default: 0};
			op(`OPC_RETURN_SUB, 1'h0, 1'h1, e);
			check("enable after return", 0, global_interrupt_enable);
			op(`OPC_RETURN_FROM_INTERRUPT, 1'h0, 1'h1, e);
			check("enable after interrupt return", 1, global_interrupt_enable);
			e = '{pc_load: 1'h1, pc_value: 13'h0004, stack_push: 1'h1, push_value: return_address, default: 0};
			op(`OPC_FILE_CLEAR_VALUE, 1'h1, 1'h1, e);
			check("enable after vectoring", 0, global_interrupt_enable);
			op(14'h0000, 1'h1, 1'h0, '0);
			e = '{watchdog_counter_clear: 1'h1, prescaler_clear: 1'h1, timeout_status_bit_set: 1'h1,
				powerdown_status_bit_set: 1'h1, default: 0};
			op(`OPC_WATCHDOG_CLEAR, 1'h0, 1'h0, e);
			e = '{file_write: 1'h1, file_addr: k[6:0], zero_set: 1'h1, default: 0};
			op(`OPC_FILE_CLEAR_VALUE | {7'h00, k[6:0]}, 1'h0, 1'h0, e);
			e = '{w_write: 1'h1, zero_set: 1'h1, default: 0};
			op(`OPC_ACC_CLEAR_VALUE | {7'h00, k[6:0]}, 1'h0, 1'h0, e);
			interrupt_control_write = 1'h1;
			interrupt_control_wdata = 8'h80 | k;
			op(14'h0000, 1'h0, 1'h0, '0);
			check("enable after software set", 1, global_interrupt_enable);
			interrupt_control_wdata = 8'h7F & k;
			op(14'h0000, 1'h0, 1'h0, '0);
			interrupt_control_write = 1'h0;
			check("enable after software clear", 0, global_interrupt_enable);
			e = '{pc_load: 1'h1, pc_value: stack_top_entry, stack_pop: 1'h1, default: 0};
			op(`OPC_RETURN_FROM_INTERRUPT, 1'h0, 1'h1, e);
			rstn = 1'h0;
			repeat (2) @(posedge clk);
			#10 rstn = 1'h1;
			check("enable after reset", 0, global_interrupt_enable);
			check("quarter after reset", 0, quarter);
		end
		repeat (4) @(posedge clk);
		check("pending notes", 0, notes.size());
		end_of_test();
	end
endmodule
